// ### flash_erase_control.sv
// Program/erase sequencer for an 8-Kbyte nonvolatile array behind an AXI4-Lite slave
//
// How it works
// - Page erase clears all 64 bytes of the selected page, two rows.
// - Erased bits read as one, programmed bits read as zero.
// - High voltage sets only with program or erase selected and sequence completed.
// - High-voltage bit drives the charge pump and array high voltage outputs.
// - Whole-array select makes the erase cover the entire 8-Kbyte array.
// - Program and erase select are never one together nor set together.
// - Whole-array erase is refused whenever the protect byte is not all ones.
// - Steps keep their order; unrelated accesses between steps never abort.
// - High voltage is refused when the target lies in the protected range.
// - Protect bits are address 13..6; bits 15,14 one, bits 5..0 zero.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module flash_erase_control
  import flash_erase_control_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Array high voltage
  output logic high_voltage_on,
  output logic charge_pump_on,
  output logic erase_busy
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Map a bus address to a register or the array window
  function automatic region_t decode(input logic [31:0] a);
    if (a == OFF_CONTROL) decode = REG_CTRL;
    else if (a == OFF_PROTECT) decode = REG_PROT;
    else if (a == OFF_STATUS) decode = REG_STAT;
    else if (a[31:16] == ARRAY_HIGH_ZERO && a[ARRAY_SEL_BIT]) decode = REG_ARRAY;
    else decode = REG_NONE;
  endfunction

  // Byte index at or above the protect start address
  function automatic logic in_protect(input logic [IDX_W-1:0] idx, input logic [7:0] bp);
    in_protect = (bp != PROTECT_RESET) &&
                 ({ARRAY_TOP_BITS, idx} >= {PROT_TOP_BITS, bp, PROT_LOW_BITS});
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mem [ARRAY_BYTES];
  logic pgm_q, erase_q, mass_q, high_voltage_enable_q;
  logic pgm_d, erase_d, mass_d, high_voltage_enable_d;
  logic [7:0] bp_q;
  seq_t seq_q;
  logic [IDX_W-1:0] page_q;
  logic sel_mass_q;
  logic sweep_q;
  logic [IDX_W-1:0] sweep_idx_q, sweep_end_q;
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_wr, ctrl_wr, prot_wr, arr_wr, prot_rd, prot_target, sweep_start, both_set;
  region_t wr_reg, rd_reg;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wbyte;

  // Write and read decode
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;
  assign wr_reg = decode(awaddr_q);
  assign rd_reg = decode(s_axi_araddr);
  assign wr_idx = awaddr_q[IDX_W+1:2];
  assign wbyte = wdata_q[7:0];
  assign ctrl_wr = do_wr && wr_reg == REG_CTRL && wstrb0_q;
  assign prot_wr = do_wr && wr_reg == REG_PROT && wstrb0_q;
  assign arr_wr = do_wr && wr_reg == REG_ARRAY && wstrb0_q;
  assign prot_rd = s_axi_arvalid && arready_q && rd_reg == REG_PROT;
  assign prot_target = sel_mass_q ? (bp_q != PROTECT_RESET) : in_protect(page_q, bp_q);
  assign both_set = wbyte[BIT_PGM] && wbyte[BIT_ERASE];

  // ----------------------------------------------------------------
  // Control register next value
  // ----------------------------------------------------------------
  always_comb
  begin
    pgm_d = pgm_q;
    erase_d = erase_q;
    mass_d = mass_q;
    high_voltage_enable_d = high_voltage_enable_q;
    if (ctrl_wr)
    begin
      mass_d = wbyte[BIT_MASS];
      if (!both_set)
      begin
        // A select may only rise while the other one is clear
        pgm_d = wbyte[BIT_PGM] && (pgm_q || !erase_q);
        erase_d = wbyte[BIT_ERASE] && (erase_q || !pgm_q);
      end
      if (!wbyte[BIT_HIGH_VOLTAGE_ENABLE])
        high_voltage_enable_d = 1'b0;
      else if (seq_q == SEQ_LATCHED && !prot_target && (pgm_d || erase_d))
        high_voltage_enable_d = 1'b1;
    end
  end

  // Erase fires when the erase select drops while high voltage is applied
  assign sweep_start = ctrl_wr && seq_q == SEQ_HV_ON && erase_q && !erase_d && high_voltage_enable_q && !sweep_q &&
                       !prot_target;

  // Control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pgm_q <= CTRL_RESET;
      erase_q <= CTRL_RESET;
      mass_q <= CTRL_RESET;
      high_voltage_enable_q <= CTRL_RESET;
    end
    else
    begin
      pgm_q <= pgm_d;
      erase_q <= erase_d;
      mass_q <= mass_d;
      high_voltage_enable_q <= high_voltage_enable_d;
    end
  end

  // Block protect byte, alterable only while no operation is selected
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bp_q <= PROTECT_RESET;
    else if (prot_wr && seq_q == SEQ_IDLE && !pgm_q && !erase_q)
      bp_q <= wbyte;
  end

  // ----------------------------------------------------------------
  // Sequence tracker: advances only on its own steps, so other accesses never abort it
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_q <= SEQ_IDLE;
      page_q <= IDX_FIRST;
      sel_mass_q <= 1'b0;
    end
    else
    begin
      case (seq_q)
        SEQ_IDLE:
          if (pgm_q || erase_q) seq_q <= SEQ_SELECTED;
        SEQ_SELECTED:
          if (!pgm_q && !erase_q) seq_q <= SEQ_IDLE;
          else if (prot_rd) seq_q <= SEQ_PROT_READ;
        SEQ_PROT_READ:
          if (!pgm_q && !erase_q) seq_q <= SEQ_IDLE;
          else if (arr_wr || (prot_wr && erase_q && mass_q))
          begin
            // Selecting write latches the target page and the erase scope
            seq_q <= SEQ_LATCHED;
            page_q <= prot_wr ? IDX_LAST : wr_idx;
            sel_mass_q <= erase_q && mass_q;
          end
        SEQ_LATCHED:
          if (!pgm_q && !erase_q) seq_q <= SEQ_IDLE;
          else if (high_voltage_enable_q) seq_q <= SEQ_HV_ON;
        SEQ_HV_ON:
          if (!high_voltage_enable_q) seq_q <= SEQ_IDLE;
        default:
          seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Erase sweep: one byte per clock over a page or the whole array
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sweep_q <= 1'b0;
      sweep_idx_q <= IDX_FIRST;
      sweep_end_q <= IDX_FIRST;
    end
    else if (sweep_start)
    begin
      sweep_q <= 1'b1;
      sweep_idx_q <= sel_mass_q ? IDX_FIRST : (page_q & PAGE_MASK);
      sweep_end_q <= sel_mass_q ? IDX_LAST : ((page_q & PAGE_MASK) | PAGE_LAST);
    end
    else if (sweep_q)
    begin
      if (sweep_idx_q == sweep_end_q)
        sweep_q <= 1'b0;
      else
        sweep_idx_q <= sweep_idx_q + 1'b1;
    end
  end

  // Array contents: erase to ones, program clears bits only
  always_ff @(posedge aclk)
  begin
    if (sweep_q)
      mem[sweep_idx_q] <= ERASED_BYTE;
    else if (arr_wr && pgm_q && high_voltage_enable_q && seq_q == SEQ_HV_ON && !in_protect(wr_idx, bp_q))
      mem[wr_idx] <= mem[wr_idx] & wbyte;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= OFF_CONTROL;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_wr)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read side, answer one cycle after the address is taken
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      if (rd_reg == REG_CTRL)
        rdata_q[BIT_HIGH_VOLTAGE_ENABLE:BIT_PGM] <= {high_voltage_enable_q, mass_q, erase_q, pgm_q};
      else if (rd_reg == REG_PROT)
        rdata_q[7:0] <= bp_q;
      else if (rd_reg == REG_STAT)
        rdata_q[3:0] <= {sweep_q, seq_q};
      else if (rd_reg == REG_ARRAY)
        rdata_q[7:0] <= mem[s_axi_araddr[IDX_W+1:2]];
      else
        rresp_q <= RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign high_voltage_on = high_voltage_enable_q;
  assign charge_pump_on = high_voltage_enable_q;
  assign erase_busy = sweep_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hv_gate: assert property ($rose(high_voltage_enable_q) |-> $past(seq_q) == SEQ_LATCHED && !$past(prot_target))
    else $error("high voltage set outside a completed sequence");
  a_hv_protect: assert property ($rose(high_voltage_enable_q) |-> !$past(prot_target))
    else $error("high voltage set on a protected target");
  a_pump_track: assert property ($rose(high_voltage_enable_q) |-> high_voltage_on && charge_pump_on ##1 seq_q == SEQ_HV_ON)
    else $error("pump outputs do not follow high voltage bit");
  a_select_excl: assert property (!(pgm_q && erase_q))
    else $error("program and erase selected together");
  a_double_keep: assert property (ctrl_wr && both_set |=> pgm_q == $past(pgm_q) && erase_q == $past(erase_q))
    else $error("double select write changed the selection");
  a_mass_lock: assert property (sweep_start && sel_mass_q |-> bp_q == PROTECT_RESET)
    else $error("whole-array erase with protection active");
  a_page_span: assert property (sweep_start && !sel_mass_q |=> sweep_end_q - sweep_idx_q == PAGE_LAST)
    else $error("page erase does not span one page");
  a_mass_span: assert property (sweep_start && sel_mass_q |=> sweep_idx_q == IDX_FIRST && sweep_end_q == IDX_LAST)
    else $error("whole-array erase does not span the array");
  a_erase_ones: assert property (sweep_q |=> mem[$past(sweep_idx_q)] == ERASED_BYTE)
    else $error("erased byte is not all ones");
  a_reset_zero: assert property (disable iff (1'b0) !aresetn |=> !pgm_q && !erase_q && !mass_q && !high_voltage_enable_q)
    else $error("control register not zero after reset");

  c_page_erase: cover property (sweep_start && !sel_mass_q);
  c_mass_erase: cover property (sweep_start && sel_mass_q);
  c_program: cover property (arr_wr && pgm_q && seq_q == SEQ_HV_ON);
endmodule

// ### flash_erase_control_pkg.sv
// Constants, register map and sequence states for the nonvolatile array controller
package flash_erase_control_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite port)
  // ----------------------------------------------------------------
  localparam logic [31:0] OFF_CONTROL = 32'h0000_0000;
  localparam logic [31:0] OFF_PROTECT = 32'h0000_0004;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0008;
  localparam int ARRAY_SEL_BIT = 15;
  localparam logic [15:0] ARRAY_HIGH_ZERO = 16'h0000;
  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_PGM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_MASS = 2;
  localparam int BIT_HIGH_VOLTAGE_ENABLE = 3;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [7:0] PROTECT_RESET = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int IDX_W = 13;
  localparam int ARRAY_BYTES = 8192;
  localparam logic [IDX_W-1:0] PAGE_MASK = 13'h1fc0;
  localparam logic [IDX_W-1:0] PAGE_LAST = 13'h003f;
  localparam logic [IDX_W-1:0] IDX_FIRST = 13'h0000;
  localparam logic [IDX_W-1:0] IDX_LAST = 13'h1fff;
  localparam logic [2:0] ARRAY_TOP_BITS = 3'h7;
  localparam logic [1:0] PROT_TOP_BITS = 2'h3;
  localparam logic [5:0] PROT_LOW_BITS = 6'h00;
  // ----------------------------------------------------------------
  // Bus answers and address regions
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {REG_CTRL, REG_PROT, REG_STAT, REG_ARRAY, REG_NONE} region_t;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_SELECTED, SEQ_PROT_READ, SEQ_LATCHED, SEQ_HV_ON} seq_t;
endpackage

// ### tb.sv
// Self-checking bench for the nonvolatile array program/erase sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb
  import flash_erase_control_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and clock
  // ------------------------------------------------------------
  logic aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic high_voltage_on, charge_pump_on, erase_busy;
  int failures, samples_checked;

  // Software waits in 40 ns cycles; the block times nothing, so the erase hold is kept short
  localparam int hv_setup_delay = 250;
  localparam int hv_hold_delay = 125;
  localparam int long_hv_hold_delay = 2500;
  localparam int read_recovery_time = 25;

  // Free-running 25 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  flash_erase_control dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .high_voltage_on(high_voltage_on),
    .charge_pump_on(charge_pump_on), .erase_busy(erase_busy));

  // ------------------------------------------------------------
  // Bus access tasks
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic wrap_up;
  begin
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // Byte index to array window address
  function automatic logic [31:0] arr(input logic [IDX_W-1:0] idx);
    return {16'h0000, 1'b1, idx, 2'b00};
  endfunction

  // One write; an edge separates it from the previous release
  task automatic wr(input logic [31:0] a, input logic [31:0] dt, input logic [1:0] er);
    int n;
    logic done;
  begin
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
      end
      if (n > 50)
      begin
        failures++;
        wrap_up;
      end
    end
  end
  endtask

  // One read, data and response returned
  task automatic rd(input logic [31:0] a, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    logic done;
  begin
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        done = 1'b1;
        dt = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
      if (n > 50)
      begin
        failures++;
        wrap_up;
      end
    end
  end
  endtask

  // Read and compare against an expected word
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    logic [1:0] rs;
  begin
    rd(a, v, rs);
    `CHK(nm, RESP_OKAY, rs)
    `CHK(nm, e, v)
  end
  endtask

  // ------------------------------------------------------------
  // Sequence tasks
  // ------------------------------------------------------------
  // Page or whole-array erase; ok says whether high voltage may set
  task automatic erase_seq(input logic [31:0] la, input logic mass, input logic ok);
    int n;
  begin
    n = 0;
    wr(OFF_CONTROL, {29'h0, mass, 2'b10}, RESP_OKAY);
    rd(OFF_PROTECT, d, r);
    wr(la, 32'h0000_00ff, RESP_OKAY);
    rd_chk(OFF_STATUS, 32'h3, "status latched");
    repeat (hv_setup_delay) @(posedge aclk);
    wr(OFF_CONTROL, {28'h0, 1'b1, mass, 2'b10}, RESP_OKAY);
    `CHK("high_voltage_on", ok, high_voltage_on)
    `CHK("charge_pump_on", ok, charge_pump_on)
    if (ok)
    begin
      repeat (hv_hold_delay) @(posedge aclk);
      wr(OFF_CONTROL, 32'h8, RESP_OKAY);
      @(posedge aclk);
      `CHK("erase_busy", 1'b1, erase_busy)
      while (erase_busy !== 1'b0)
      begin
        @(posedge aclk);
        n++;
        if (n > 9000)
        begin
          failures++;
          wrap_up;
        end
      end
      repeat (mass ? long_hv_hold_delay : hv_hold_delay) @(posedge aclk);
    end
    wr(OFF_CONTROL, 32'h0, RESP_OKAY);
    repeat (read_recovery_time) @(posedge aclk);
    `CHK("hv released", 1'b0, charge_pump_on)
  end
  endtask

  // Program one byte; ok says whether high voltage may set
  task automatic prog(input logic [IDX_W-1:0] idx, input logic [7:0] dt, input logic ok);
  begin
    wr(OFF_CONTROL, 32'h1, RESP_OKAY);
    rd(OFF_PROTECT, d, r);
    wr(arr(idx), 32'h0, RESP_OKAY);
    wr(OFF_CONTROL, 32'h9, RESP_OKAY);
    `CHK("hv program", ok, high_voltage_on)
    wr(arr(idx), {24'h0, dt}, RESP_OKAY);
    wr(OFF_CONTROL, 32'h8, RESP_OKAY);
    wr(OFF_CONTROL, 32'h0, RESP_OKAY);
  end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    failures = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values
    rd_chk(OFF_CONTROL, 32'h0, "control reset");
    rd_chk(OFF_PROTECT, 32'hff, "protect reset");
    rd_chk(OFF_STATUS, 32'h0, "status reset");
    `CHK("pump reset", 1'b0, charge_pump_on)
    // Unmapped address answers with an error
    rd(32'h0000_0010, d, r);
    `CHK("unmapped rresp", RESP_SLVERR, r)
    wr(32'h0000_0010, 32'h1, RESP_SLVERR);
    // High voltage refused without select or without protect read
    wr(OFF_CONTROL, 32'h8, RESP_OKAY);
    rd_chk(OFF_CONTROL, 32'h0, "hv no select");
    wr(OFF_CONTROL, 32'h2, RESP_OKAY);
    wr(arr(13'h0000), 32'h0, RESP_OKAY);
    wr(OFF_CONTROL, 32'ha, RESP_OKAY);
    rd_chk(OFF_CONTROL, 32'h2, "hv no protect read");
    // Select interlock
    wr(OFF_CONTROL, 32'h3, RESP_OKAY);
    rd_chk(OFF_CONTROL, 32'h2, "erase then both");
    wr(OFF_CONTROL, 32'h0, RESP_OKAY);
    wr(OFF_CONTROL, 32'h3, RESP_OKAY);
    rd_chk(OFF_CONTROL, 32'h0, "both together");
    wr(OFF_CONTROL, 32'h1, RESP_OKAY);
    wr(OFF_CONTROL, 32'h2, RESP_OKAY);
    rd_chk(OFF_CONTROL, 32'h0, "program then erase");
    wr(OFF_CONTROL, 32'h0, RESP_OKAY);
    // Sequences come from the bench, never from array contents
    // Whole-array erase, then both ends read erased
    erase_seq(arr(13'h0100), 1'b1, 1'b1);
    rd_chk(arr(IDX_FIRST), 32'hff, "mass first");
    rd_chk(arr(IDX_LAST), 32'hff, "mass last");
    // Programming clears bits only
    prog(13'h003f, 8'h00, 1'b1);
    prog(13'h0040, 8'h5a, 1'b1);
    prog(13'h0040, 8'h0f, 1'b1);
    rd_chk(arr(13'h0040), 32'h0a, "programmed and");
    // Page erase covers its 64 bytes only
    erase_seq(arr(13'h0010), 1'b0, 1'b1);
    rd_chk(arr(13'h003f), 32'hff, "page end erased");
    rd_chk(arr(13'h0040), 32'h0a, "next page kept");
    // Protection from index 0x40 upward
    wr(OFF_PROTECT, 32'h81, RESP_OKAY);
    rd_chk(OFF_PROTECT, 32'h81, "protect write");
    erase_seq(arr(13'h0000), 1'b1, 1'b0);
    erase_seq(arr(13'h0040), 1'b0, 1'b0);
    prog(13'h003f, 8'h00, 1'b1);
    prog(13'h0040, 8'h00, 1'b0);
    rd_chk(arr(13'h0040), 32'h0a, "protected kept");
    rd_chk(arr(13'h003f), 32'h00, "below range");
    // Whole-array erase selected through the protect register
    wr(OFF_PROTECT, 32'hff, RESP_OKAY);
    erase_seq(OFF_PROTECT, 1'b1, 1'b1);
    rd_chk(arr(13'h0040), 32'hff, "mass via protect");
    rd_chk(OFF_CONTROL, 32'h0, "control idle");
    wrap_up;
  end
endmodule
